// ===== logic/adsc_sequencer.sv
`timescale 1ns/1ns
// How it works
// - code 000: go keeps sampling one instruction cycle, then converts
// - nonzero code samples selected periods, then converts
// - done clears go, sets flag, resumes sampling
// - no acquisition or conversion phase status shown
// - conversion takes exactly eleven bit periods
// - clock select picks divider or rc
// - analog pins read back as zero
// - channel and direction never gate conversion
// - code 000 waits one instruction cycle
// - code 010 gives four period acquisition
// - abort on go clear keeps result
// - two period wait, then sampling resumes
// - trigger sets go, resets timer counter
// - converter off: trigger only resets timer
// - sample capacitor disconnects at conversion start
// - acquisition codes map to 0..20 periods
// - justify bit right or left aligns result
// - reset turns off and aborts everything
module adsc_sequencer
    import adsc_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk_i,
    input  wire logic                  reset_i,
    // software control bits
    input  wire logic                  converter_on_i,
    input  wire logic                  go_set_i,     // write of go as 1
    input  wire logic                  go_clear_i,   // write of go as 0
    input  wire adsc_pkg::adsc_cfg_t   cfg_i,        // acq_clock_config
    input  wire logic [3:0]            channel_sel_i,
    input  wire logic                  irq_flag_clear_i,
    // software writes of the result pair
    input  wire logic                  res_wr_high_i,
    input  wire logic                  res_wr_low_i,
    input  wire logic [7:0]            res_wr_data_i,
    // capture unit two
    input  wire logic [3:0]            capture_unit_mode_sel_i,
    input  wire logic                  special_event_i, // same clock
    // analog side
    input  wire logic                  rc_clk_i,      // internal rc osc
    input  wire logic                  comparator_i,  // sar comparator
    // port pins
    input  wire logic [PORT_PINS-1:0]  port_pin_i,
    input  wire logic [PORT_PINS-1:0]  analog_cfg_i,  // 1 analog
    // status and results
    output logic                       go_flag_o,
    output logic                       conv_done_irq_flag_o,
    output adsc_pkg::adsc_result_t     result_o,
    output logic                       timer_reset_o,  // one cycle
    // analog front end control
    output logic                       sample_connect_o,
    output logic [3:0]                 channel_o,
    output logic [RESULT_BITS-1:0]     sar_trial_o,
    // port read back
    output logic [PORT_PINS-1:0]       port_read_o
);

    // ========================================================
    // declarations
    // ========================================================
    typedef enum logic [2:0] {
        ST_IDLE,     // sampling when on, waiting for go
        ST_INSTR,    // one instruction cycle before converting
        ST_ACQ,      // programmed acquisition
        ST_CONV,     // successive approximation
        ST_RECOVER   // mandatory gap before sampling
    } adsc_state_t;

    adsc_state_t              state;        // sequencer state
    logic                     tick;         // one pulse per bit period
    logic                     tick_run;     // divider runs in timed states
    logic                     rc_level;     // synced rc clock
    logic                     cmp_level;    // comparator level, taken unsynced
    logic [PORT_PINS-1:0]     pin_level;    // synced pins
    logic [PERIOD_CNT_W-1:0]  period_cnt;   // bit periods in state
    logic [2:0]               instr_cnt;    // ref clocks in ST_INSTR
    logic [RESULT_BITS-1:0]   sar_bits;     // decided bits
    logic [RESULT_BITS-1:0]   sar_mask;     // bit under test
    logic                     trigger_hit;  // special event in mode
    logic                     go_request;   // any source sets go
    logic                     abort;        // go cleared or converter off
    logic                     conv_finish;  // last conversion period
    logic [RESULT_BITS-1:0]   final_code;   // code with last bit decided

    // ========================================================
    // input synchronisers and bit period clock
    // ========================================================
    // rc clock is foreign; comparator reads our own trial word
    assign cmp_level = comparator_i;  // two flops outlast a /2 period
    adsc_sync #(
        .WIDTH (1)
    ) u_sync_analog (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   (rc_clk_i),
        .sync_o    (rc_level)
    );

    // pin levels are asynchronous too
    adsc_sync #(
        .WIDTH (PORT_PINS)
    ) u_sync_pins (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .async_i   (port_pin_i),
        .sync_o    (pin_level)
    );

    // divider only runs while a timed phase is under way
    assign tick_run = ((state == ST_ACQ) || (state == ST_CONV)
                   || (state == ST_RECOVER)) && !abort;

    adsc_tick_gen u_tick (
        .ref_clk_i        (ref_clk_i),
        .reset_i          (reset_i),
        .run_i            (tick_run),
        .conv_clock_sel_i (cfg_i.conv_clock_sel),
        .rc_level_i       (rc_level),
        .tick_o           (tick)
    );

    // ========================================================
    // go sources and abort
    // ========================================================
    // trigger counts only in the right capture mode
    assign trigger_hit = special_event_i
                      && (capture_unit_mode_sel_i == TRIGGER_MODE);
    // converter off blocks both sources from setting go
    assign go_request  = converter_on_i
                      && (go_set_i || trigger_hit);
    // go cleared by software, or the converter switched off
    assign abort       = go_flag_o && (go_clear_i || !converter_on_i);

    // last period of the conversion, result lands here
    assign conv_finish = (state == ST_CONV) && tick
                      && (period_cnt == PERIOD_CNT_W'(CONV_PERIODS - 1));

    // bit under test settled with the comparator at this tick
    assign final_code  = cmp_level ? (sar_bits | sar_mask) : sar_bits;

    // ========================================================
    // sequencer state
    // ========================================================
    // counts advance on ticks except in the instruction wait, so acquisition,
    // conversion and recovery scale with the selected bit period
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state      <= ST_IDLE;
            period_cnt <= '0;
            instr_cnt  <= '0;
        end else begin
            case (state)
                // waiting; a pending go from recovery also starts here
                ST_IDLE: begin
                    period_cnt <= '0;
                    instr_cnt  <= '0;
                    if (go_flag_o && converter_on_i && !go_clear_i) begin
                        if (cfg_i.acq_time_sel == ACQ_NONE) begin
                            state <= ST_INSTR;
                        end else begin
                            state <= ST_ACQ;
                        end
                    end
                end
                // one instruction cycle so a sleep can go first
                ST_INSTR: begin
                    if (abort) begin
                        state <= ST_RECOVER;
                    end else if (instr_cnt ==
                                 3'(INSTR_CYCLE_CLKS - 1)) begin
                        state <= ST_CONV;
                    end else begin
                        instr_cnt <= instr_cnt + 3'h1;
                    end
                end
                // keep sampling for the programmed periods
                ST_ACQ: begin
                    if (abort) begin
                        state      <= ST_RECOVER;
                        period_cnt <= '0;
                    end else if (tick) begin
                        if (period_cnt ==
                            acq_periods(cfg_i.acq_time_sel) - 5'h01) begin
                            state      <= ST_CONV;
                            period_cnt <= '0;
                        end else begin
                            period_cnt <= period_cnt + 5'h01;
                        end
                    end
                end
                // eleven periods, aborted by go clear
                ST_CONV: begin
                    if (abort) begin
                        state      <= ST_RECOVER;
                        period_cnt <= '0;
                    end else if (conv_finish) begin
                        state      <= ST_RECOVER;
                        period_cnt <= '0;
                    end else if (tick) begin
                        period_cnt <= period_cnt + 5'h01;
                    end
                end
                // two periods with the sampler open
                ST_RECOVER: begin
                    if (tick) begin
                        if (period_cnt ==
                            PERIOD_CNT_W'(RECOVER_PERIODS - 1)) begin
                            state      <= ST_IDLE;
                            period_cnt <= '0;
                        end else begin
                            period_cnt <= period_cnt + 5'h01;
                        end
                    end
                end
                default: begin
                    state      <= ST_IDLE;
                    period_cnt <= '0;
                end
            endcase
        end
    end

    // ========================================================
    // go flag
    // ========================================================
    // the only activity indication; no phase status leaves the block
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            go_flag_o <= 1'b0;
        end else if (conv_finish && !abort) begin
            go_flag_o <= 1'b0;
        end else if (go_request && !go_flag_o) begin
            go_flag_o <= 1'b1;
        end else if (go_clear_i || !converter_on_i) begin
            go_flag_o <= 1'b0;
        end
    end

    // ========================================================
    // done flag
    // ========================================================
    // a completion in the clearing cycle wins, so none is lost
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            conv_done_irq_flag_o <= 1'b0;
        end else if (conv_finish && !abort) begin
            conv_done_irq_flag_o <= 1'b1;
        end else if (irq_flag_clear_i) begin
            conv_done_irq_flag_o <= 1'b0;
        end
    end

    // ========================================================
    // successive approximation
    // ========================================================
    // bits decided msb first on the first ten periods, the eleventh
    // period only transfers; trial word drives the dac
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sar_bits    <= '0;
            sar_mask    <= '0;
            sar_trial_o <= '0;
        end else if (state != ST_CONV) begin
            sar_bits    <= '0;
            sar_mask    <= {1'b1, {(RESULT_BITS-1){1'b0}}};
            sar_trial_o <= {1'b1, {(RESULT_BITS-1){1'b0}}};
        end else if (tick && (sar_mask != '0)) begin
            sar_bits    <= final_code;
            sar_mask    <= sar_mask >> 1;
            sar_trial_o <= final_code | (sar_mask >> 1);
        end
    end

    // ========================================================
    // result pair
    // ========================================================
    // reset leaves nothing in flight; abort never loads the pair
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            result_o <= {RESULT_RESET, RESULT_RESET};
        end else if (conv_finish && !abort) begin
            if (cfg_i.result_justify) begin
                // right justified, upper bits of high byte read zero
                result_o.result_high_byte <= {6'h00, sar_bits[9:8]};
                result_o.result_low_byte  <= sar_bits[7:0];
            end else begin
                // left justified, lower bits of low byte read zero
                result_o.result_high_byte <= sar_bits[9:2];
                result_o.result_low_byte  <= {sar_bits[1:0], 6'h00};
            end
        end else begin
            // software may load its own value; kept on abort
            if (res_wr_high_i) begin
                result_o.result_high_byte <= res_wr_data_i;
            end
            if (res_wr_low_i) begin
                result_o.result_low_byte <= res_wr_data_i;
            end
        end
    end

    // ========================================================
    // sampler, channel and timer reset
    // ========================================================
    // sampler closed while idle, instruction wait and acquisition;
    // opens one ref clock after conversion begins
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sample_connect_o <= 1'b0;
        end else begin
            sample_connect_o <= converter_on_i
                             && (state != ST_CONV)
                             && (state != ST_RECOVER);
        end
    end

    // channel goes straight through; pin direction never gates it,
    // an output pin is simply converted at its driven level
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            channel_o <= '0;
        end else begin
            channel_o <= channel_sel_i;
        end
    end

    // timer counter reset follows every trigger, on or off
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            timer_reset_o <= 1'b0;
        end else begin
            timer_reset_o <= trigger_hit;
        end
    end

    // ========================================================
    // port read back
    // ========================================================
    // analog pins read low so a floating level cannot leak into
    // software; digital pins pass their synced level
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            port_read_o <= '0;
        end else begin
            port_read_o <= pin_level & ~analog_cfg_i;
        end
    end

endmodule : adsc_sequencer

// ===== pkg/adsc_pkg.sv
package adsc_pkg;

    // ========================================================
    // timing
    // ========================================================
    localparam int OSC_PERIOD_PS  = 10000;  // ref clock period, 100 MHz
    localparam int INSTR_CYCLE_PS = 40000;  // one instruction cycle
    // instruction cycle in ref clocks, least time so rounded up
    localparam int INSTR_CYCLE_CLKS =
        (INSTR_CYCLE_PS + OSC_PERIOD_PS - 1) / OSC_PERIOD_PS;
    localparam int CONV_PERIODS    = 11;    // bit periods per conversion
    localparam int RECOVER_PERIODS = 2;     // wait after done or abort
    localparam int RESULT_BITS     = 10;    // converter resolution

    // ========================================================
    // field codes
    // ========================================================
    localparam logic [3:0] TRIGGER_MODE   = 4'hb; // special event mode
    localparam logic [2:0] ACQ_NONE       = 3'h0; // no auto acquisition
    localparam logic [1:0] CLK_SEL_RC     = 2'h3; // low bits of rc code
    localparam int         MAX_DIV_LOG2   = 6;    // divide by 64 at most
    localparam int         PERIOD_CNT_W   = 5;    // holds up to 20
    localparam int         PORT_PINS      = 16;   // analog capable pins

    // reset values
    localparam logic [2:0] ACQ_RESET      = 3'h0;
    localparam logic [7:0] RESULT_RESET   = 8'h00;

    // ========================================================
    // carriers
    // ========================================================
    typedef struct packed {
        logic       result_justify;  // 1 right, 0 left
        logic [2:0] acq_time_sel;    // auto acquisition length
        logic [2:0] conv_clock_sel;  // bit period source
    } adsc_cfg_t;

    typedef struct packed {
        logic [7:0] result_high_byte;
        logic [7:0] result_low_byte;
    } adsc_result_t;

    // acquisition code to bit periods
    function automatic logic [PERIOD_CNT_W-1:0] acq_periods(
        input logic [2:0] code);
        case (code)
            3'h7:    acq_periods = 5'h14;
            3'h6:    acq_periods = 5'h10;
            3'h5:    acq_periods = 5'h0c;
            3'h4:    acq_periods = 5'h08;
            3'h3:    acq_periods = 5'h06;
            3'h2:    acq_periods = 5'h04;
            3'h1:    acq_periods = 5'h02;
            default: acq_periods = 5'h00;
        endcase
    endfunction : acq_periods

endpackage : adsc_pkg

// ===== logic/adsc_sync.sv
`timescale 1ns/1ns
module adsc_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    // asynchronous level in, synchronised level out
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    // ========================================================
    // two flop synchroniser
    // ========================================================
    logic [WIDTH-1:0] stage1;  // only read by the second flop

    // first stage may go metastable, nothing but sync_o reads it
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            stage1 <= '0;
            sync_o <= '0;
        end else begin
            stage1 <= async_i;
            sync_o <= stage1;
        end
    end

endmodule : adsc_sync

// ===== logic/adsc_tick_gen.sv
`timescale 1ns/1ns
module adsc_tick_gen
    import adsc_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       reset_i,
    // control
    input  wire logic       run_i,          // low holds the phase at zero
    input  wire logic [2:0] conv_clock_sel_i,
    input  wire logic       rc_level_i,     // rc clock, already synced
    // one cycle pulse per bit period
    output logic            tick_o
);

    // ========================================================
    // bit period divider
    // ========================================================
    logic [MAX_DIV_LOG2-1:0] div_cnt;   // free running while run_i, divider codes only
    logic [MAX_DIV_LOG2-1:0] div_last;  // terminal count for the code
    logic                    rc_mode;   // internal rc selected
    logic                    rc_prev;   // for rising edge detect

    assign rc_mode = (conv_clock_sel_i[1:0] == CLK_SEL_RC);

    // code bits map 000,100,001,101,010,110 to /2../64
    always_comb begin
        case ({conv_clock_sel_i[1:0], conv_clock_sel_i[2]})
            3'b000:  div_last = 6'h01;
            3'b001:  div_last = 6'h03;
            3'b010:  div_last = 6'h07;
            3'b011:  div_last = 6'h0f;
            3'b100:  div_last = 6'h1f;
            3'b101:  div_last = 6'h3f;
            default: div_last = 6'h01;
        endcase
    end

    // counter restarts on run so the first period is a full one
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            div_cnt <= '0;
            rc_prev <= 1'b0;
            tick_o  <= 1'b0;
        end else begin
            rc_prev <= rc_level_i;
            if (!run_i) begin
                div_cnt <= '0;
                tick_o  <= 1'b0;
            end else if (rc_mode) begin
                // first edge only arms
                div_cnt[0] <= div_cnt[0] | (rc_level_i & ~rc_prev);
                tick_o     <= div_cnt[0] & rc_level_i & ~rc_prev;
            end else if (div_cnt == div_last) begin
                div_cnt <= '0;
                tick_o  <= 1'b1;
            end else begin
                div_cnt <= div_cnt + 6'h01;
                tick_o  <= 1'b0;
            end
        end
    end

endmodule : adsc_tick_gen

// ===== dv/adsc_chk.sv
`timescale 1ns/1ns
module adsc_chk
    import adsc_pkg::*;
(
    // clock and reset
    input wire logic             ref_clk_i,
    input wire logic             reset_i,
    // inputs seen
    input wire logic             converter_on_i,
    input wire logic             go_set_i,
    input wire logic             go_clear_i,
    input wire logic             res_wr_high_i,
    input wire logic             res_wr_low_i,
    input wire logic [3:0]       capture_unit_mode_sel_i,
    input wire logic             special_event_i,
    input wire logic [15:0]      analog_cfg_i,
    // outputs watched
    input wire logic             go_flag_o,
    input wire logic             conv_done_irq_flag_o,
    input wire adsc_result_t     result_o,
    input wire logic             timer_reset_o,
    input wire logic             sample_connect_o,
    input wire logic [15:0]      port_read_o
);
    // ========================================
    // one domain: clock and reset given once
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (reset_i);
    // trigger that the capture unit really asks for
    wire trig = special_event_i && capture_unit_mode_sel_i == TRIGGER_MODE;
    a_go_cause: assert property ($rose(go_flag_o) |->
        $past(converter_on_i) && $past(go_set_i || trig)) else $error("go");
    a_off_idle: assert property (!converter_on_i && !go_flag_o |=>
        !go_flag_o) else $error("go while off");
    a_abort_go: assert property (go_clear_i && go_flag_o |=>
        !go_flag_o) else $error("abort ignored");
    a_done_go: assert property ($rose(conv_done_irq_flag_o) |->
        $fell(go_flag_o)) else $error("done without go drop");
    a_done_open: assert property ($rose(conv_done_irq_flag_o) |->
        !sample_connect_o) else $error("sampler closed at once");
    a_timer_pulse: assert property (trig |=> timer_reset_o)
        else $error("timer reset missing");
    a_timer_cause: assert property (timer_reset_o |-> $past(trig))
        else $error("stray timer reset");
    a_result_hold: assert property (!$stable(result_o) |->
        $fell(go_flag_o) || $past(res_wr_high_i || res_wr_low_i))
        else $error("result changed");
    a_analog_zero: assert property (
        (port_read_o & $past(analog_cfg_i)) == 16'h0000)
        else $error("analog pin read high");
endmodule : adsc_chk

// ===== dv/test_adsc_sequencer.sv
`timescale 1ns/1ns
module test_adsc_sequencer;
    import adsc_pkg::*;
    // ========================================
    logic ref_clk_i, reset_i, converter_on_i, go_set_i, go_clear_i;
    logic irq_flag_clear_i, res_wr_high_i, res_wr_low_i, special_event_i;
    logic rc_clk_i, go_flag_o, conv_done_irq_flag_o, dprev;
    logic timer_reset_o, sample_connect_o;
    logic [3:0] channel_sel_i, capture_unit_mode_sel_i, channel_o;
    logic [7:0] res_wr_data_i;
    logic [9:0] vin, sar_trial_o;  // analog level as a code
    logic [15:0] port_pin_i, analog_cfg_i, port_read_o;
    adsc_cfg_t cfg_i;
    adsc_result_t result_o, keep;
    adsc_result_t exp_q[$];  // expected results, oldest first
    int lat_q[$], win_q[$];  // length floor and slack
    int fails = 0, n_compared = 0, cyc = 0, t0 = 0, seed;
    int ap[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
    wire comparator_i = vin >= sar_trial_o;  // ideal comparator
    adsc_sequencer adsc_sequencer_i (.*);
    initial begin
        ref_clk_i = 0;
        forever #5 ref_clk_i = ~ref_clk_i;
    end
    // rc source, 80 ns, phase unrelated to the ref clock
    initial begin
        rc_clk_i = 0;
        #3 forever #40 rc_clk_i = ~rc_clk_i;
    end
    always @(posedge ref_clk_i) cyc <= cyc + 1;
    task automatic bad(input string m);
        fails++;
        $display("[FAIL] %0t %s", $time, m);
    endtask : bad
    task automatic chk_res(input adsc_result_t e);
        n_compared++;
        if (result_o !== e) bad("result word");
    endtask : chk_res
    task automatic chk_bit(input logic g, e, input string m);
        n_compared++;
        if (g !== e) bad(m);
    endtask : chk_bit
    task automatic chk_lat(input int g, lo, w);
        n_compared++;
        if (g < lo || g > lo + w) bad("conversion length");
    endtask : chk_lat
    task automatic clk(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : clk
    // watcher: each fresh done flag takes the oldest note
    always @(negedge ref_clk_i) begin
        if (conv_done_irq_flag_o === 1'b1 && dprev === 1'b0) begin
            if (exp_q.size() == 0) bad("unexpected completion");
            else begin
                chk_res(exp_q.pop_front());
                chk_lat(cyc - t0, lat_q.pop_front(), win_q.pop_front());
            end
        end
        dprev = conv_done_irq_flag_o;
    end
    // one conversion, started by a go write or by the trigger
    task automatic convert(input logic [2:0] a, c, input logic j, tr);
        int d;
        d = (c[1:0] == 2'h3) ? 8 : 2 << (c[2] + 2 * c[1:0]);
        cfg_i = '{j, a, c};
        vin = 10'($random(seed));
        channel_sel_i = 4'($random(seed));
        irq_flag_clear_i = 1;
        clk(1);
        irq_flag_clear_i = 0;
        go_set_i = !tr;
        special_event_i = tr;
        t0 = cyc;
        exp_q.push_back(j ? {6'h00, vin} : {vin, 6'h00});
        lat_q.push_back((11 + ap[a]) * d + (a == 0 ? 6 : 2));
        win_q.push_back(d + 12);
        clk(1);
        {go_set_i, special_event_i} = 2'b00;
        clk(1);
        for (int i = 0; i < 3000 && go_flag_o !== 1'b0; i++) clk(1);
        chk_bit(go_flag_o, 1'b0, "go stuck");
        chk_bit(channel_o === channel_sel_i, 1'b1, "channel");
        clk(2 * d + 6);
        chk_bit(sample_connect_o, 1'b1, "sampler not back");
    endtask : convert
    task automatic give_verdict();
        $display("compared %0d, failed %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : give_verdict
    initial begin
        #400000;
        bad("watchdog");
        give_verdict();
    end
    initial begin
        seed = 32'hb7894056;
        reset_i = 1;
        {converter_on_i, go_set_i, go_clear_i, irq_flag_clear_i} = '0;
        {res_wr_high_i, res_wr_low_i, special_event_i, dprev} = '0;
        {res_wr_data_i, channel_sel_i, capture_unit_mode_sel_i} = '0;
        {port_pin_i, analog_cfg_i, vin, cfg_i} = '0;
        clk(12);
        reset_i = 0;
        chk_res(16'h0000);
        converter_on_i = 1;
        clk(2);
        for (int k = 0; k < 8; k++) convert(3'h0, 3'(k), k[0], 0);
        capture_unit_mode_sel_i = TRIGGER_MODE;
        for (int k = 1; k < 8; k++) convert(3'(k), 3'h0, k[0], k[1]);
        $display("test conversions finished");
        keep = result_o;
        cfg_i = '{1'b1, 3'h0, 3'h6};
        go_set_i = 1;
        clk(1);
        go_set_i = 0;
        clk(300);
        go_clear_i = 1;
        clk(1);
        go_clear_i = 0;
        clk(1);
        chk_bit(go_flag_o, 1'b0, "abort ignored");
        chk_res(keep);
        clk(140);
        chk_bit(sample_connect_o, 1'b1, "no resample");
        {res_wr_high_i, res_wr_data_i} = {1'b1, 8'($random(seed))};
        keep = {res_wr_data_i, ~res_wr_data_i};
        clk(1);
        {res_wr_high_i, res_wr_low_i} = 2'b01;
        res_wr_data_i = ~res_wr_data_i;
        clk(1);
        res_wr_low_i = 0;
        clk(1);
        chk_res(keep);
        $display("test abort finished");
        converter_on_i = 0;
        for (int m = 10; m < 12; m++) begin
            capture_unit_mode_sel_i = 4'(m);
            special_event_i = 1;
            clk(1);
            special_event_i = 0;
            chk_bit(timer_reset_o, m == 11, "timer reset");
            clk(3);
            chk_bit(go_flag_o, 1'b0, "go while off");
        end
        repeat (8) begin
            {port_pin_i, analog_cfg_i} = $random(seed);
            clk(4);
            n_compared++;
            if (port_read_o !== (port_pin_i & ~analog_cfg_i)) bad("pins");
        end
        $display("test trigger and pins finished");
        converter_on_i = 1;
        clk(1);
        go_set_i = 1;
        clk(1);
        go_set_i = 0;
        clk(50);
        reset_i = 1;
        clk(2);
        chk_bit(go_flag_o, 1'b0, "reset kept go");
        reset_i = 0;
        clk(2);
        $display("test reset finished");
        give_verdict();
    end
endmodule : test_adsc_sequencer
bind adsc_sequencer adsc_chk adsc_chk_i (.*);
